/* bench/stb_bridge_tb.sv */
// Purpose: Self-checking bench for the SCSI to tape data path
// Assumes: Inputs change at the falling edge of clk_sys
// Notes: Each scenario task judges its own results

`timescale 1ns/10ps

`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end

// ==========================================================
// Bench top
module stb_bridge_tb;
  import stb_pkg::*;
  logic clk_sys, resetn, cpu_cmd_valid, cpu_irq_ack, seq_irq, pio_rd, pio_wr, pio_rvalid;
  logic [7:0] cpu_cmd, pio_wdata, pio_rdata, scsi_in_data, scsi_out_data, tape_wdata, tape_rdata;
  logic scsi_sel, scsi_host_out, scsi_data_phase, scsi_in_valid, scsi_in_ready, scsi_out_valid;
  logic scsi_out_ready, dma_to_tape, buf_wr_valid, buf_wr_ready, buf_rd_valid, buf_rd_ready;
  logic [WORD_W-1:0] buf_wr_data, buf_rd_data;
  logic tape_wstrobe, tape_wpar, tape_wr_avail, tape_rstrobe, tape_rpar, tape_rd_space;
  logic perr_clr, perr_flag, host_err;
  int errors = 0;
  int cmp_count = 0;

  stb_bridge u_dut (.clk_sys(clk_sys), .resetn(resetn), .cpu_cmd_valid(cpu_cmd_valid), .cpu_cmd(cpu_cmd),
    .cpu_irq_ack(cpu_irq_ack), .seq_irq(seq_irq), .pio_rd(pio_rd), .pio_wr(pio_wr), .pio_wdata(pio_wdata),
    .pio_rdata(pio_rdata), .pio_rvalid(pio_rvalid), .scsi_sel(scsi_sel), .scsi_host_out(scsi_host_out),
    .scsi_data_phase(scsi_data_phase), .scsi_in_valid(scsi_in_valid), .scsi_in_data(scsi_in_data),
    .scsi_in_ready(scsi_in_ready), .scsi_out_valid(scsi_out_valid), .scsi_out_data(scsi_out_data),
    .scsi_out_ready(scsi_out_ready), .dma_to_tape(dma_to_tape), .buf_wr_valid(buf_wr_valid),
    .buf_wr_data(buf_wr_data), .buf_wr_ready(buf_wr_ready), .buf_rd_valid(buf_rd_valid),
    .buf_rd_data(buf_rd_data), .buf_rd_ready(buf_rd_ready), .tape_wstrobe(tape_wstrobe),
    .tape_wdata(tape_wdata), .tape_wpar(tape_wpar), .tape_wr_avail(tape_wr_avail),
    .tape_rstrobe(tape_rstrobe), .tape_rdata(tape_rdata), .tape_rpar(tape_rpar),
    .tape_rd_space(tape_rd_space), .perr_clr(perr_clr), .perr_flag(perr_flag));

  stb_host_model u_host (.clk_sys(clk_sys), .scsi_sel(scsi_sel), .scsi_host_out(scsi_host_out),
    .scsi_data_phase(scsi_data_phase), .scsi_in_valid(scsi_in_valid), .scsi_in_data(scsi_in_data),
    .scsi_in_ready(scsi_in_ready), .scsi_out_valid(scsi_out_valid), .scsi_out_data(scsi_out_data),
    .scsi_out_ready(scsi_out_ready), .host_err(host_err));

  // ==========================================================
  // Clock and helpers
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  function automatic logic odd(input logic [7:0] b);
    return ~^b;
  endfunction : odd

  task automatic end_sim();
    $display("Counts: %0d checks, %0d mismatches", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  task automatic pio_read(input logic [7:0] exp);
    @(negedge clk_sys);
    pio_rd = 1'b1;
    @(negedge clk_sys);
    pio_rd = 1'b0;
    `CHK({pio_rvalid, pio_rdata}, {1'b1, exp})
  endtask : pio_read

  task automatic pio_write(input logic [7:0] b);
    @(negedge clk_sys);
    pio_wr = 1'b1;
    pio_wdata = b;
    @(negedge clk_sys);
    pio_wr = 1'b0;
  endtask : pio_write

  // Buffer word toward the tape or SCSI FIFO, held until taken
  task automatic buf_push(input logic [8:0] w);
    int n;
    n = 0;
    buf_rd_valid = 1'b1;
    buf_rd_data = w;
    #1;
    while (!buf_rd_ready && n < 100) begin
      @(negedge clk_sys);
      #1;
      n++;
    end
    if (n >= 100) begin
      errors++;
      $display("[ERR] %0t wait ran out", $time);
      end_sim();
    end
    @(negedge clk_sys);
  endtask : buf_push

  task automatic tape_pop(input logic [8:0] w);
    @(negedge clk_sys);
    tape_wstrobe = 1'b1;
    @(negedge clk_sys);
    tape_wstrobe = 1'b0;
    `CHK({tape_wpar, tape_wdata}, w)
  endtask : tape_pop

  // ==========================================================
  // Scenarios
  task automatic t_cmd_seq(input logic [7:0] cdb0, input int len);
    logic [7:0] q[$];
    q = {8'h80, cdb0};
    for (int i = 1; i < len; i++) q.push_back(8'(i * 7));
    u_host.phase(1'b1, 1'b0);
    @(negedge clk_sys);
    cpu_cmd = 8'h01;
    cpu_cmd_valid = 1'b1;
    @(negedge clk_sys);
    cpu_cmd_valid = 1'b0;
    u_host.select();
    foreach (q[i]) begin
      `CHK(seq_irq, 1'b0)
      u_host.send(q[i]);
    end
    u_host.stop();
    `CHK(seq_irq, 1'b1)
    foreach (q[i]) pio_read(q[i]);
    @(negedge clk_sys);
    cpu_irq_ack = 1'b1;
    @(negedge clk_sys);
    cpu_irq_ack = 1'b0;
    `CHK(seq_irq, 1'b0)
    $display("t_cmd_seq %h done", cdb0);
  endtask : t_cmd_seq

  task automatic t_pio_out();
    logic [7:0] got;
    u_host.phase(1'b0, 1'b0);
    pio_write(8'h3c);
    pio_write(8'hc3);
    u_host.recv(3, got);
    `CHK(got, 8'h3c)
    u_host.recv(1, got);
    `CHK(got, 8'hc3)
    `CHK(scsi_out_valid, 1'b0)
    $display("t_pio_out done");
  endtask : t_pio_out

  task automatic t_fifo_full();
    u_host.phase(1'b1, 1'b0);
    for (int i = 0; i < 16; i++) u_host.send(8'(i + 'h40));
    u_host.stop();
    #1;
    `CHK(scsi_in_ready, 1'b0)
    for (int i = 0; i < 16; i++) pio_read(8'(i + 'h40));
    #1;
    `CHK(scsi_in_ready, 1'b1)
    $display("t_fifo_full done");
  endtask : t_fifo_full

  task automatic t_dma_in(input logic busy);
    logic [7:0] bs[3];
    int c, k, last;
    time t0;
    bs = '{8'h11, 8'h22, 8'h34};
    k = 0;
    last = 0;
    @(negedge clk_sys);
    dma_to_tape = 1'b1;
    buf_wr_ready = 1'b1;
    if (busy) buf_push(9'h1a5);
    buf_rd_valid = 1'b0;
    u_host.phase(1'b1, 1'b1);
    fork
      begin
        t0 = $time;
        foreach (bs[i]) u_host.send(bs[i]);
        u_host.stop();
        `CHK(int'(($time - t0) / 20), 3)
      end
      for (c = 0; c < 300 && k < 3; c++) begin
        @(negedge clk_sys);
        #1;
        if (buf_wr_valid) begin
          `CHK(buf_wr_data, {odd(bs[k]), bs[k]})
          if (k > 0) `CHK(c - last, busy ? 42 : 25)
          last = c;
          k++;
        end
      end
    join
    `CHK(k, 3)
    u_host.phase(1'b0, 1'b0);
    if (busy) tape_pop(9'h1a5);
    repeat (50) @(negedge clk_sys);
    $display("t_dma_in %0d done", busy);
  endtask : t_dma_in

  task automatic t_tape_wr();
    logic [8:0] w[16];
    time t0;
    foreach (w[i]) w[i] = {odd(8'(i * 29 + 3)), 8'(i * 29 + 3)};
    w[7][8] = ~w[7][8];
    dma_to_tape = 1'b1;
    u_host.phase(1'b0, 1'b0);
    `CHK(tape_wr_avail, 1'b0)
    t0 = $time;
    foreach (w[i]) buf_push(w[i]);
    buf_rd_valid = 1'b0;
    buf_rd_data = ~buf_rd_data;
    `CHK(int'(($time - t0) / 20), 16)
    #1;
    `CHK({buf_rd_ready, tape_wr_avail}, 2'b01)
    foreach (w[i]) tape_pop(w[i]);
    `CHK(tape_wr_avail, 1'b0)
    tape_pop(w[15]);
    $display("t_tape_wr done");
  endtask : t_tape_wr

  // Buffer to SCSI host data phase, paced by the sustained gap
  task automatic t_dma_out();
    logic [7:0] got;
    time t0;
    dma_to_tape = 1'b0;
    buf_wr_ready = 1'b0;
    u_host.phase(1'b0, 1'b1);
    buf_push(9'h15a);
    t0 = $time;
    buf_push(9'h0c3);
    buf_rd_valid = 1'b0;
    `CHK(int'(($time - t0) / 20), 25)
    u_host.recv(1, got);
    `CHK(got, 8'h5a)
    u_host.recv(1, got);
    `CHK(got, 8'hc3)
    u_host.phase(1'b0, 1'b0);
    $display("t_dma_out done");
  endtask : t_dma_out

  task automatic t_tape_rd();
    logic [8:0] w[16];
    int c, k;
    k = 0;
    foreach (w[i]) w[i] = {odd(8'(i * 13 + 1)), 8'(i * 13 + 1)};
    w[5][8] = ~w[5][8];
    dma_to_tape = 1'b0;
    buf_wr_ready = 1'b0;
    u_host.phase(1'b0, 1'b0);
    foreach (w[i]) begin
      @(negedge clk_sys);
      tape_rstrobe = 1'b1;
      {tape_rpar, tape_rdata} = w[i];
      @(negedge clk_sys);
      tape_rstrobe = 1'b0;
      {tape_rpar, tape_rdata} = ~w[i];
      `CHK(perr_flag, i >= 5)
    end
    `CHK(tape_rd_space, 1'b0)
    buf_wr_ready = 1'b1;
    for (c = 0; c < 64 && k < 16; c++) begin
      #1;
      if (buf_wr_valid) begin
        `CHK(buf_wr_data, w[k])
        k++;
      end
      @(negedge clk_sys);
    end
    `CHK(k, 16)
    `CHK(perr_flag, 1'b1)
    perr_clr = 1'b1;
    @(negedge clk_sys);
    perr_clr = 1'b0;
    `CHK(perr_flag, 1'b0)
    @(negedge clk_sys);
    tape_rstrobe = 1'b1;
    {tape_rpar, tape_rdata} = w[5];
    perr_clr = 1'b1;
    @(negedge clk_sys);
    {tape_rstrobe, perr_clr} = 2'b00;
    `CHK(perr_flag, 1'b1)
    $display("t_tape_rd done");
  endtask : t_tape_rd

  // ==========================================================
  // Main sequence
  initial begin
    {resetn, cpu_cmd_valid, cpu_irq_ack, pio_rd, pio_wr, dma_to_tape, buf_wr_ready} = 7'h00;
    {buf_rd_valid, tape_wstrobe, tape_rstrobe, tape_rpar, perr_clr} = 5'h00;
    {cpu_cmd, pio_wdata, tape_rdata} = 24'h000000;
    buf_rd_data = 9'h000;
    repeat (8) @(negedge clk_sys);
    resetn = 1'b1;
    `CHK({seq_irq, perr_flag, tape_wr_avail, tape_rd_space}, 4'h1)
    t_cmd_seq(8'h00, 6);
    t_cmd_seq(8'h28, 10);
    t_cmd_seq(8'h40, 10);
    t_cmd_seq(8'ha0, 12);
    t_cmd_seq(8'h60, 6);
    t_pio_out();
    t_fifo_full();
    t_dma_in(1'b0);
    t_dma_in(1'b1);
    t_tape_wr();
    t_dma_out();
    t_tape_rd();
    `CHK(host_err, 1'b0)
    end_sim();
  end
endmodule : stb_bridge_tb

/* bench/stb_host_model.sv */
// Purpose: SCSI initiator model facing the bridge byte streams
// Assumes: Lines change just after the falling edge of clk_sys
// Notes: A released data line shows the inverse of its last byte

`timescale 1ns/10ps

// ==========================================================
// Host model
module stb_host_model (
  input wire logic clk_sys,
  output logic scsi_sel,
  output logic scsi_host_out,
  output logic scsi_data_phase,
  output logic scsi_in_valid,
  output logic [7:0] scsi_in_data,
  input wire logic scsi_in_ready,
  input wire logic scsi_out_valid,
  input wire logic [7:0] scsi_out_data,
  output logic scsi_out_ready,
  output logic host_err
);
  // Idle bus at time zero
  initial begin
    scsi_sel = 1'b0;
    scsi_host_out = 1'b0;
    scsi_data_phase = 1'b0;
    scsi_in_valid = 1'b0;
    scsi_in_data = 8'h00;
    scsi_out_ready = 1'b0;
    host_err = 1'b0;
  end

  // Bus phase levels
  task automatic phase(input logic ho, input logic dp);
    @(negedge clk_sys);
    scsi_host_out = ho;
    scsi_data_phase = dp;
  endtask : phase

  // One cycle of selection
  task automatic select();
    @(negedge clk_sys);
    scsi_sel = 1'b1;
    @(negedge clk_sys);
    scsi_sel = 1'b0;
  endtask : select

  // One byte toward the device, held until taken
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    scsi_in_valid = 1'b1;
    scsi_in_data = b;
    #1;
    while (!scsi_in_ready && n < 100) begin
      @(negedge clk_sys);
      #1;
      n++;
    end
    if (n >= 100) host_err = 1'b1;
    @(negedge clk_sys);
  endtask : send

  // Release the outgoing byte lines
  task automatic stop();
    scsi_in_valid = 1'b0;
    scsi_in_data = ~scsi_in_data;
  endtask : stop

  // One byte from the device, after a stall of some cycles
  task automatic recv(input int stall, output logic [7:0] got);
    int n;
    n = 0;
    repeat (stall) @(negedge clk_sys);
    scsi_out_ready = 1'b1;
    #1;
    while (!scsi_out_valid && n < 100) begin
      @(negedge clk_sys);
      #1;
      n++;
    end
    if (n >= 100) host_err = 1'b1;
    got = scsi_out_data;
    @(negedge clk_sys);
    scsi_out_ready = 1'b0;
  endtask : recv
endmodule : stb_host_model

/* hdl/stb_bridge.sv */
// Purpose: Data path between a SCSI controller and a tape unit bus
// Assumes: All inputs synchronous to clk_sys; buffer is external
// Notes: Command bytes reach the processor through the SCSI FIFO

`timescale 1ns/10ps

// ==========================================================
// Top
module stb_bridge import stb_pkg::*; (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cpu_cmd_valid,
  input wire logic [7:0] cpu_cmd,
  input wire logic cpu_irq_ack,
  output logic seq_irq,
  input wire logic pio_rd,
  input wire logic pio_wr,
  input wire logic [7:0] pio_wdata,
  output logic [7:0] pio_rdata,
  output logic pio_rvalid,
  input wire logic scsi_sel,
  input wire logic scsi_host_out,
  input wire logic scsi_data_phase,
  input wire logic scsi_in_valid,
  input wire logic [7:0] scsi_in_data,
  output logic scsi_in_ready,
  output logic scsi_out_valid,
  output logic [7:0] scsi_out_data,
  input wire logic scsi_out_ready,
  input wire logic dma_to_tape,
  output logic buf_wr_valid,
  output logic [WORD_W-1:0] buf_wr_data,
  input wire logic buf_wr_ready,
  input wire logic buf_rd_valid,
  input wire logic [WORD_W-1:0] buf_rd_data,
  output logic buf_rd_ready,
  input wire logic tape_wstrobe,
  output logic [7:0] tape_wdata,
  output logic tape_wpar,
  output logic tape_wr_avail,
  input wire logic tape_rstrobe,
  input wire logic [7:0] tape_rdata,
  input wire logic tape_rpar,
  output logic tape_rd_space,
  input wire logic perr_clr,
  output logic perr_flag
);

  // ==========================================================
  // Declarations
  stb_fifo_if sf_if ();
  stb_fifo_if tw_if ();
  stb_fifo_if tr_if ();

  stb_seq_t seq_q, seq_d;
  logic [3:0] rem_q, rem_d;
  logic [3:0] len_q, len_d;
  logic [3:0] taken_q, taken_d;
  logic [PACE_W-1:0] pace_q, pace_d;
  logic [7:0] pio_rdata_q, pio_rdata_d;
  logic pio_rvalid_q, pio_rvalid_d;
  logic [7:0] twd_q, twd_d;
  logic twp_q, twp_d;
  logic perr_q, perr_d;

  logic seq_busy;
  logic to_int;
  logic scsi_dma;
  logic pace_ok;
  logic tape_act;
  logic acc;
  logic sf_to_buf;
  logic buf_to_sf;
  logic scsi_mv;
  logic pio_pop;
  logic rd_bad;
  logic [3:0] grp_len;

  // ==========================================================
  // FIFOs
  stb_fifo u_scsi_fifo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .port(sf_if.store)
  );

  stb_fifo u_twr_fifo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .port(tw_if.store)
  );

  stb_fifo u_trd_fifo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .port(tr_if.store)
  );

  // ==========================================================
  // Path steering
  // Direction and owner of the SCSI FIFO
  always_comb begin
    seq_busy = (seq_q == S_IDENT) || (seq_q == S_CDB0) || (seq_q == S_CDB);
    to_int = seq_busy | scsi_host_out;
    scsi_dma = scsi_data_phase & ~seq_busy; // Only data phase uses DMA
    pace_ok = (pace_q == RST_PACE);
    tape_act = ~tw_if.empty | ~tr_if.empty;
    acc = scsi_in_valid & scsi_in_ready;
  end

  // SCSI side handshakes, one byte per clock
  assign scsi_in_ready = to_int & ~sf_if.full;
  assign scsi_out_valid = ~to_int & ~sf_if.empty;
  assign scsi_out_data = sf_if.rdata[7:0];

  // DMA moves between SCSI FIFO and buffer, paced
  always_comb begin
    sf_to_buf = to_int & scsi_dma & dma_to_tape & pace_ok & ~sf_if.empty;
    buf_to_sf = ~to_int & scsi_dma & ~dma_to_tape & pace_ok & ~sf_if.full;
    pio_pop = pio_rd & to_int & ~scsi_dma & ~sf_if.empty;
    scsi_mv = (sf_to_buf & buf_wr_ready) | (buf_to_sf & buf_rd_valid);
  end

  // SCSI FIFO push source and pop sink
  always_comb begin
    if (to_int) begin
      sf_if.push = scsi_in_valid;
      sf_if.wdata = {stb_odd_par(scsi_in_data), scsi_in_data};
      sf_if.pop = scsi_dma ? (sf_to_buf & buf_wr_ready) : pio_pop;
    end else if (scsi_dma) begin
      sf_if.push = buf_to_sf & buf_rd_valid;
      sf_if.wdata = buf_rd_data;
      sf_if.pop = scsi_out_ready;
    end else begin
      sf_if.push = pio_wr; // Status and message out by processor
      sf_if.wdata = {stb_odd_par(pio_wdata), pio_wdata};
      sf_if.pop = scsi_out_ready;
    end
  end

  // Buffer ports shared by SCSI and tape DMA
  always_comb begin
    if (dma_to_tape) begin
      buf_wr_valid = sf_to_buf;
      buf_wr_data = sf_if.rdata;
      buf_rd_ready = ~tw_if.full; // Burst while room
    end else begin
      buf_wr_valid = ~tr_if.empty; // Burst while data
      buf_wr_data = tr_if.rdata;
      buf_rd_ready = buf_to_sf;
    end
  end

  // Tape FIFO pushes and pops
  always_comb begin
    tw_if.push = dma_to_tape & buf_rd_valid;
    tw_if.wdata = buf_rd_data;
    tw_if.pop = tape_wstrobe;
    tr_if.push = tape_rstrobe;
    tr_if.wdata = {tape_rpar, tape_rdata};
    tr_if.pop = ~dma_to_tape & buf_wr_ready;
  end

  assign tape_wr_avail = ~tw_if.empty;
  assign tape_rd_space = ~tr_if.full;

  // ==========================================================
  // Command sequencer
  // Command length from the group field
  always_comb begin
    case (scsi_in_data[GRP_LSB +: 3])
      GRP_SIX: grp_len = LEN_SIX;
      GRP_TEN_A: grp_len = LEN_TEN;
      GRP_TEN_B: grp_len = LEN_TEN;
      GRP_TWELVE: grp_len = LEN_TWELVE;
      default: grp_len = LEN_SIX;
    endcase
  end

  // Selection, Identify, command bytes, interrupt
  always_comb begin
    seq_d = seq_q;
    rem_d = rem_q;
    len_d = len_q;
    taken_d = seq_busy ? (taken_q + 4'(acc)) : RST_CNT;
    unique case (seq_q)
      S_IDLE: begin
        if (cpu_cmd_valid && (cpu_cmd == CMD_SEL_RX)) begin
          seq_d = S_ARMED;
        end
      end
      S_ARMED: begin
        if (scsi_sel) begin
          seq_d = S_IDENT;
        end
      end
      S_IDENT: begin
        if (acc) begin
          seq_d = S_CDB0;
        end
      end
      S_CDB0: begin
        if (acc) begin
          len_d = grp_len;
          rem_d = grp_len - 4'h1;
          seq_d = S_CDB;
        end
      end
      S_CDB: begin
        if (acc) begin
          rem_d = rem_q - 4'h1;
          if (rem_q == 4'h1) begin
            seq_d = S_DONE;
          end
        end
      end
      S_DONE: begin
        if (cpu_irq_ack) begin
          seq_d = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      seq_q <= S_IDLE;
      rem_q <= RST_CNT;
      len_q <= RST_CNT;
      taken_q <= RST_CNT;
    end else begin
      seq_q <= seq_d;
      rem_q <= rem_d;
      len_q <= len_d;
      taken_q <= taken_d;
    end
  end

  assign seq_irq = (seq_q == S_DONE);

  // ==========================================================
  // Rate pacing
  // Gap after each SCSI DMA byte
  always_comb begin
    if (scsi_mv) begin
      pace_d = tape_act ? PACE_CONC : PACE_SUST;
    end else if (!pace_ok) begin
      pace_d = pace_q - 6'h01;
    end else begin
      pace_d = pace_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pace_q <= RST_PACE;
    end else begin
      pace_q <= pace_d;
    end
  end

  // ==========================================================
  // Processor byte port and tape output
  // Read data latch, write-side tape byte, parity error
  always_comb begin
    pio_rvalid_d = pio_pop;
    pio_rdata_d = pio_pop ? sf_if.rdata[7:0] : pio_rdata_q;
    twd_d = twd_q;
    twp_d = twp_q;
    if (tape_wstrobe && !tw_if.empty) begin
      twd_d = tw_if.rdata[7:0];
      twp_d = tw_if.rdata[PAR_BIT]; // Buffer ninth bit
    end
    rd_bad = tape_rstrobe & ~(^{tape_rpar, tape_rdata});
    perr_d = (perr_q & ~perr_clr) | rd_bad; // Set beats clear
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pio_rvalid_q <= RST_FLAG;
      pio_rdata_q <= RST_BYTE;
      twd_q <= RST_BYTE;
      twp_q <= RST_FLAG;
      perr_q <= RST_FLAG;
    end else begin
      pio_rvalid_q <= pio_rvalid_d;
      pio_rdata_q <= pio_rdata_d;
      twd_q <= twd_d;
      twp_q <= twp_d;
      perr_q <= perr_d;
    end
  end

  assign pio_rvalid = pio_rvalid_q;
  assign pio_rdata = pio_rdata_q;
  assign tape_wdata = twd_q;
  assign tape_wpar = twp_q;
  assign perr_flag = perr_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  a_seq_cmd_len: assert property (
    (seq_q == S_CDB && acc && rem_q == 4'h1) |=> seq_irq && (taken_q == len_q + 4'h1))
    else $error("command sequence byte count wrong");

  a_seq_irq_hold: assert property (
    (seq_irq && !cpu_irq_ack) |=> seq_irq)
    else $error("interrupt dropped before ack");

  a_pio_no_dma: assert property (
    (!scsi_data_phase || seq_busy) |-> !sf_to_buf && !buf_to_sf)
    else $error("DMA moved a non data byte");

  a_dma_data_move: assert property (
    (scsi_dma && to_int && dma_to_tape && pace_ok && !sf_if.empty)
      |-> buf_wr_valid && (buf_wr_data == sf_if.rdata))
    else $error("data phase byte not offered to buffer");

  a_burst_accept: assert property (
    (to_int && !sf_if.full) |-> scsi_in_ready)
    else $error("SCSI input stalled with room");

  a_pace_gap: assert property (
    (scsi_mv && !tape_act) |=> (pace_q == PACE_SUST) ##1 !scsi_mv [*8])
    else $error("sustained rate gap too short");

  a_pace_conc: assert property (
    (scsi_mv && tape_act) |=> (pace_q == PACE_CONC))
    else $error("concurrent rate gap wrong");

  a_tape_wr_feed: assert property (
    (tape_wstrobe && !tw_if.empty) |=> (tape_wdata == $past(tw_if.rdata[7:0])))
    else $error("tape write byte not presented");

  a_burst_fill: assert property (
    (dma_to_tape && !tw_if.full) |-> buf_rd_ready)
    else $error("tape write FIFO not filled by DMA");

  a_wpar_ninth: assert property (
    (tape_wstrobe && !tw_if.empty) |=> (tape_wpar == $past(tw_if.rdata[PAR_BIT])))
    else $error("tape parity bit not from buffer");

  a_rd_par_chk: assert property (
    (tape_rstrobe && !(^{tape_rpar, tape_rdata})) |=> perr_flag)
    else $error("bad read parity not flagged");

  a_perr_sticky: assert property (
    (perr_flag && !perr_clr) |=> perr_flag)
    else $error("parity error flag lost");

endmodule : stb_bridge

/* hdl/stb_fifo.sv */
// Purpose: Sixteen-word first-in first-out store
// Assumes: Single clock, synchronous reset
// Notes: Read data shows the head word while not empty

`timescale 1ns/10ps

// ==========================================================
// FIFO
module stb_fifo import stb_pkg::*; (
  input wire logic clk_sys,
  input wire logic resetn,
  stb_fifo_if.store port
);

  logic [WORD_W-1:0] mem_q [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
  logic [FIFO_AW:0] cnt_q, cnt_d;
  logic do_push, do_pop;

  // Pointer and fill arithmetic
  always_comb begin
    do_push = port.push & ~port.full;
    do_pop = port.pop & ~port.empty;
    wptr_d = wptr_q + FIFO_AW'(do_push);
    rptr_d = rptr_q + FIFO_AW'(do_pop);
    cnt_d = cnt_q + (FIFO_AW+1)'(do_push) - (FIFO_AW+1)'(do_pop);
  end

  // Honest flags from the fill count
  assign port.full = (cnt_q == (FIFO_AW+1)'(FIFO_DEPTH));
  assign port.empty = (cnt_q == RST_FCNT);
  assign port.rdata = mem_q[rptr_q];

  // Pointer registers
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wptr_q <= RST_PTR;
      rptr_q <= RST_PTR;
      cnt_q <= RST_FCNT;
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      mem_q[wptr_q] <= port.wdata;
    end
  end

  // ==========================================================
  // Checks
  a_fifo_fill_bound: assert property (@(posedge clk_sys) disable iff (!resetn)
    (cnt_q <= 5'h10) && (port.full == (cnt_q == 5'h10)) && (port.empty == (cnt_q == 5'h00)))
    else $error("fifo fill count out of range");

  a_fifo_push_count: assert property (@(posedge clk_sys) disable iff (!resetn)
    (port.push && !port.full && !port.pop) |=> (cnt_q == $past(cnt_q) + 5'h01))
    else $error("fifo push did not raise count");

endmodule : stb_fifo

/* hdl/stb_fifo_if.sv */
// Purpose: Push/pop signals between the bridge and one FIFO
// Assumes: Word is a byte plus its parity bit
// Notes: Push while full and pop while empty are ignored

`timescale 1ns/10ps

// ==========================================================
// Interface
interface stb_fifo_if;
  import stb_pkg::*;
  logic push;
  logic [WORD_W-1:0] wdata;
  logic full;
  logic pop;
  logic [WORD_W-1:0] rdata;
  logic empty;
  modport store (input push, input wdata, input pop, output full, output rdata, output empty);
  modport user (output push, output wdata, output pop, input full, input rdata, input empty);
endinterface : stb_fifo_if

/* hdl/stb_pkg.sv */
// Purpose: Shared constants and types for the SCSI to tape data path
// Assumes: One 50 MHz clock, synchronous active-low reset
// Notes: Widths and depths are fixed, not parameters

// ==========================================================
// Package
package stb_pkg;

  // ==========================================================
  // Clock and rates
  localparam int CLK_HZ = 50_000_000;
  localparam int SUST_BPS = 2_000_000; // Sustained SCSI ceiling
  localparam int SUST_CYC = (CLK_HZ + SUST_BPS - 1) / SUST_BPS;
  localparam int CONC_BPS = 1_200_000; // Ceiling with tape busy
  localparam int CONC_CYC = (CLK_HZ + CONC_BPS - 1) / CONC_BPS;
  localparam int PACE_W = 6;
  localparam logic [PACE_W-1:0] PACE_SUST = PACE_W'(SUST_CYC - 1);
  localparam logic [PACE_W-1:0] PACE_CONC = PACE_W'(CONC_CYC - 1);
  localparam logic [PACE_W-1:0] RST_PACE = 6'h00;

  // ==========================================================
  // FIFO geometry
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam int WORD_W = 9;
  localparam int PAR_BIT = 8;
  localparam logic [FIFO_AW:0] RST_FCNT = 5'h00;
  localparam logic [FIFO_AW-1:0] RST_PTR = 4'h0;

  // ==========================================================
  // Command sequence
  localparam logic [7:0] CMD_SEL_RX = 8'h01; // Respond to selection
  localparam int GRP_LSB = 5;
  localparam logic [2:0] GRP_SIX = 3'h0;
  localparam logic [2:0] GRP_TEN_A = 3'h1;
  localparam logic [2:0] GRP_TEN_B = 3'h2;
  localparam logic [2:0] GRP_TWELVE = 3'h5;
  localparam logic [3:0] LEN_SIX = 4'h6;
  localparam logic [3:0] LEN_TEN = 4'ha;
  localparam logic [3:0] LEN_TWELVE = 4'hc;
  localparam logic [3:0] RST_CNT = 4'h0;
  localparam logic RST_FLAG = 1'b0;
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef enum {S_IDLE, S_ARMED, S_IDENT, S_CDB0, S_CDB, S_DONE} stb_seq_t;

  // Odd parity bit for one byte
  function automatic logic stb_odd_par(input logic [7:0] b);
    return ~^b;
  endfunction : stb_odd_par

endpackage : stb_pkg
